// >>> ppm_power_ctrl.sv
// Power-mode controller of a 10/100 transceiver with an APB register file.
// Assumes pins arrive asynchronously; ref clock is sampled, not used as clock.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ppm_power_ctrl
  import ppm_pkg::*;
#(
  parameter int NLP_TICKS_P = NLP_TICKS // Link-pulse interval in ticks.
) (
  input wire logic pclk, // APB clock, 50 MHz.
  input wire logic presetn, // Hardware reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic ref_clock_input, // Reference clock pin, sampled.
  input wire logic energy_sense, // Line energy on either pair.
  input wire logic link_up, // Link established.
  input wire logic core_pwr_ok, // Core supply present.
  output var ppm_pwr_type pwr_o, // Block enables and mode flags.
  output logic energy_present_out // Energy-present pin.
);

  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] NLP_LIM = CNT_W'(NLP_TICKS_P - 1);
  localparam logic [CNT_W-1:0] ENERGY_DETECT_POWERDOWN_LIM =
    CNT_W'(NLP_TICKS_P * ENERGY_DETECT_POWERDOWN_STRETCH - 1);
  localparam logic [3:0] SLOW_LIM = 4'(SLOW_DIV_CYCLES - 1);

  typedef struct packed {
    logic [15:0] bcr;
    logic [15:0] dig;
    logic [15:0] afe0;
    logic [15:0] afe2;
    logic [15:0] afe3;
    logic [15:0] exp;
    logic [15:0] pc2;
    logic [15:0] nv_afe3;
    logic nv_afe2;
    ppm_mode_type mode;
    logic [CNT_W-1:0] pulse_cnt;
    logic [3:0] slow_div;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ppm_pwr_type pwr;
    logic sig_out;
  } ppm_state_type;

  ppm_state_type s_q;
  ppm_state_type s_d;
  ppm_pins_type pins_raw;
  ppm_pins_type lvl;
  ppm_pins_type rise;

  assign pins_raw = '{energy: energy_sense, link_up: link_up,
                      core_ok: core_pwr_ok, ref_clk: ref_clock_input};

  ppm_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins_i(pins_raw),
    .lvl_o(lvl),
    .rise_o(rise)
  );

  logic [5:0] idx;
  logic wr_go;
  logic mapped;
  logic locked;
  assign idx = paddr[7:2];
  assign wr_go = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;
  assign mapped = (idx == IDX_BASIC_CTRL) || (idx == IDX_DIG_CTRL) ||
                  (idx == IDX_AFE_CTRL0) || (idx == IDX_AFE_CTRL2) ||
                  (idx == IDX_AFE_CTRL3) || (idx == IDX_EXP_CTRL) ||
                  (idx == IDX_PWR_STATUS) || (idx == IDX_PHY_CTRL2);
  // Register access survives sleep only while the slow oscillator is kept.
  assign locked = (s_q.mode == PM_SLEEP) && !s_q.afe2[AFE2_SLOW_KEEP];

  function automatic logic [15:0] rd_word(input ppm_state_type s,
                                          input logic [5:0] i,
                                          input ppm_pins_type p);
    logic [15:0] w;
    w = 16'h0000;
    unique case (i)
      IDX_BASIC_CTRL: w = s.bcr;
      IDX_DIG_CTRL: w = s.dig;
      IDX_AFE_CTRL0: w = s.afe0;
      IDX_AFE_CTRL2: w = s.afe2;
      IDX_AFE_CTRL3: w = s.afe3;
      IDX_EXP_CTRL: w = s.exp;
      IDX_PHY_CTRL2: w = s.pc2;
      IDX_PWR_STATUS: w = {11'h000, p.link_up, p.energy, s.pwr.ref_conn,
                           s.mode};
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : rd_word

  logic an_on;
  logic no_link;
  logic ps_cond;
  logic energy_detect_powerdown_cond;
  logic uds_go;
  logic tick;
  logic [CNT_W-1:0] lim;

  always_comb begin
    s_d = s_q;
    s_d.pwr.soft_rst = 1'b0;
    s_d.pwr.link_pulse = 1'b0;
    // APB: answer one cycle after setup, ready for exactly one cycle.
    s_d.pready = psel & ~penable;
    s_d.pslverr = psel & ~penable & (~mapped | locked);
    s_d.prdata = {16'h0000, rd_word(s_q, idx, lvl)};
    if (wr_go) begin
      unique case (idx)
        IDX_BASIC_CTRL: begin
          s_d.bcr = pwdata[15:0] & 16'h7fff;
          if (pwdata[BCR_SOFT_RST]) begin
            // Soft reset restores volatile bits; retained copies are kept.
            s_d.bcr = BASIC_CTRL_RST;
            s_d.dig = ZERO_RST;
            s_d.afe0 = ZERO_RST;
            s_d.exp = EXP_CTRL_RST;
            s_d.pc2 = ZERO_RST;
            s_d.pwr.soft_rst = 1'b1;
          end
        end
        IDX_DIG_CTRL: s_d.dig = pwdata[15:0];
        IDX_AFE_CTRL0: s_d.afe0 = pwdata[15:0];
        IDX_AFE_CTRL2: begin
          s_d.afe2 = pwdata[15:0];
          // Only the access bit already held in 14h opens the copy of bit 0.
          if (s_q.afe3[AFE3_NV_ACCESS]) begin
            s_d.nv_afe2 = pwdata[AFE2_SLOW_KEEP];
          end
        end
        IDX_AFE_CTRL3: begin
          s_d.afe3 = pwdata[15:0] & AFE3_MASK;
          // The enable may arrive in the same write, as in the usual setup.
          if (s_q.afe3[AFE3_NV_ACCESS] | pwdata[AFE3_NV_ACCESS]) begin
            s_d.nv_afe3 = pwdata[15:0] & AFE3_MASK;
          end
        end
        IDX_EXP_CTRL: s_d.exp = pwdata[15:0];
        IDX_PHY_CTRL2: s_d.pc2 = pwdata[15:0];
        default: s_d.bcr = s_d.bcr;
      endcase
    end
    // Core supply loss wipes volatile bits; power bits return from copies.
    if (!lvl.core_ok) begin
      s_d.bcr = BASIC_CTRL_RST;
      s_d.dig = ZERO_RST;
      s_d.afe0 = ZERO_RST;
      s_d.exp = EXP_CTRL_RST;
      s_d.pc2 = ZERO_RST;
      s_d.afe3 = s_q.nv_afe3;
      s_d.afe2 = {15'h0000, s_q.nv_afe2};
    end

    an_on = s_d.bcr[BCR_AN_EN];
    no_link = ~lvl.link_up;
    ps_cond = s_d.pc2[PC2_PWR_SAVE] & an_on & no_link;
    energy_detect_powerdown_cond = ~s_d.exp[EXP_ENERGY_DETECT_POWERDOWN_OFF] & an_on & no_link;
    uds_go = s_d.afe3[AFE3_UDS_EN] &
             (s_d.afe3[AFE3_UDS_CPU] ? s_d.afe3[AFE3_UDS_ENTER]
                                     : ~lvl.energy);
    unique case (s_q.mode)
      PM_SLEEP: s_d.mode = PM_SLEEP;
      default: begin
        if (uds_go) begin
          s_d.mode = PM_SLEEP;
        end else if (s_d.bcr[BCR_PDOWN]) begin
          s_d.mode = PM_PDOWN;
        end else if (ps_cond | energy_detect_powerdown_cond) begin
          s_d.mode = PM_SAVING;
        end else begin
          s_d.mode = PM_ACTIVE;
        end
      end
    endcase

    s_d.pwr.rx_en = (s_d.mode == PM_ACTIVE);
    s_d.pwr.tx_en = (s_d.mode == PM_ACTIVE) || (s_d.mode == PM_SAVING);
    s_d.pwr.edet_en = (s_d.mode != PM_PDOWN);
    s_d.pwr.pll_en = (s_d.mode == PM_ACTIVE) || ((s_d.mode == PM_SAVING) &&
                     !(energy_detect_powerdown_cond & s_d.dig[DIG_PLL_OFF]));
    s_d.pwr.ref_conn = ~s_d.afe0[AFE0_SLOW_OSC] &
                       (s_d.mode != PM_SLEEP);
    s_d.pwr.slow_osc = s_d.afe0[AFE0_SLOW_OSC];
    s_d.pwr.uds = (s_d.mode == PM_SLEEP);
    // Forced high until enabled so the host can initialise undisturbed.
    s_d.sig_out = s_d.afe3[AFE3_UDS_EN] ?
                  (lvl.energy ^ s_d.afe3[AFE3_SIG_POL]) : 1'b1;

    // Time base: reference clock edges, or a pclk divider on slow oscillator.
    s_d.slow_div = (s_q.slow_div == SLOW_LIM) ? 4'h0 : s_q.slow_div + 4'h1;
    tick = s_q.afe0[AFE0_SLOW_OSC] ? (s_q.slow_div == SLOW_LIM) : rise.ref_clk;
    lim = (s_q.mode == PM_SAVING && energy_detect_powerdown_cond) ? ENERGY_DETECT_POWERDOWN_LIM : NLP_LIM;
    if (!s_q.pwr.tx_en || lvl.link_up) begin
      s_d.pulse_cnt = '0;
    end else if (tick) begin
      if (s_q.pulse_cnt >= lim) begin
        s_d.pulse_cnt = '0;
        s_d.pwr.link_pulse = 1'b1;
      end else begin
        s_d.pulse_cnt = s_q.pulse_cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.bcr <= BASIC_CTRL_RST;
      s_q.exp <= EXP_CTRL_RST;
      s_q.pc2 <= ZERO_RST;
      s_q.mode <= PM_ACTIVE;
      s_q.sig_out <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign pwr_o = s_q.pwr;
  assign energy_present_out = s_q.sig_out;

  property p_saving_cause;
    @(posedge pclk) disable iff (!presetn)
    s_q.mode == PM_SAVING |-> s_q.bcr[BCR_AN_EN] &&
      (s_q.pc2[PC2_PWR_SAVE] || !s_q.exp[EXP_ENERGY_DETECT_POWERDOWN_OFF]);
  endproperty
  a_saving_cause: assert property (p_saving_cause)
    else $error("saving mode without its enable");

  property p_saving_blocks;
    @(posedge pclk) disable iff (!presetn)
    s_q.mode == PM_SAVING |-> !pwr_o.rx_en && pwr_o.tx_en && pwr_o.edet_en;
  endproperty
  a_saving_blocks: assert property (p_saving_blocks)
    else $error("wrong blocks enabled in saving mode");

  property p_pll_off;
    @(posedge pclk) disable iff (!presetn)
    s_q.mode == PM_SAVING && s_q.dig[DIG_PLL_OFF] && !s_q.exp[EXP_ENERGY_DETECT_POWERDOWN_OFF]
      && !s_q.pc2[PC2_PWR_SAVE] |-> !pwr_o.pll_en;
  endproperty
  a_pll_off: assert property (p_pll_off)
    else $error("pll still on with pll-off set");

  property p_pdown_enter;
    @(posedge pclk) disable iff (!presetn)
    wr_go && idx == IDX_BASIC_CTRL && pwdata[BCR_PDOWN] && !pwdata[BCR_SOFT_RST]
      |=> (s_q.mode == PM_PDOWN || s_q.mode == PM_SLEEP) && !pwr_o.tx_en;
  endproperty
  a_pdown_enter: assert property (p_pdown_enter)
    else $error("power down not entered");

  property p_pdown_exit;
    @(posedge pclk) disable iff (!presetn)
    s_q.mode == PM_PDOWN |-> s_q.bcr[BCR_PDOWN];
  endproperty
  a_pdown_exit: assert property (p_pdown_exit)
    else $error("power down held with bit clear");

  property p_sleep_hold;
    @(posedge pclk) disable iff (!presetn)
    s_q.mode == PM_SLEEP |=> s_q.mode == PM_SLEEP && !pwr_o.tx_en
      && !pwr_o.rx_en && !pwr_o.pll_en && !pwr_o.ref_conn && pwr_o.uds;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("sleep left or outputs active");

  property p_auto_sleep;
    @(posedge pclk) disable iff (!presetn)
    s_q.afe3[AFE3_UDS_EN] && !s_q.afe3[AFE3_UDS_CPU] && !lvl.energy
      && lvl.core_ok |=> s_q.mode == PM_SLEEP;
  endproperty
  a_auto_sleep: assert property (p_auto_sleep)
    else $error("automatic sleep not entered");

  property p_energy_out;
    @(posedge pclk) disable iff (!presetn)
    s_q.afe3[AFE3_UDS_EN] && $stable(s_q.afe3) && $stable(lvl.energy) |=>
      energy_present_out == ($past(lvl.energy) ^ s_q.afe3[AFE3_SIG_POL]);
  endproperty
  a_energy_out: assert property (p_energy_out)
    else $error("energy output wrong");

  property p_slow_osc;
    @(posedge pclk) disable iff (!presetn)
    s_q.afe0[AFE0_SLOW_OSC] |-> !pwr_o.ref_conn && pwr_o.slow_osc;
  endproperty
  a_slow_osc: assert property (p_slow_osc)
    else $error("ref clock connected in slow mode");

  property p_retain;
    @(posedge pclk) disable iff (!presetn)
    $fell(lvl.core_ok) |=> s_q.afe3 == $past(s_q.nv_afe3);
  endproperty
  a_retain: assert property (p_retain)
    else $error("retained copy not restored");

  property p_reset_default;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !s_q.pc2[PC2_PWR_SAVE] && s_q.exp[EXP_ENERGY_DETECT_POWERDOWN_OFF]
      && s_q.nv_afe3 == 16'h0000;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("low-power bits not at default");

endmodule : ppm_power_ctrl
`default_nettype wire

// >>> ppm_pkg.sv
// Shared constants and carrier types for the transceiver power-mode block.
// Assumes a 50 MHz APB clock and registers at word index times four.
package ppm_pkg;

  // Register indexes; byte address is four times the index.
  localparam logic [5:0] IDX_BASIC_CTRL = 6'h00;
  localparam logic [5:0] IDX_DIG_CTRL = 6'h10;
  localparam logic [5:0] IDX_AFE_CTRL0 = 6'h11;
  localparam logic [5:0] IDX_AFE_CTRL2 = 6'h13;
  localparam logic [5:0] IDX_AFE_CTRL3 = 6'h14;
  localparam logic [5:0] IDX_EXP_CTRL = 6'h18;
  localparam logic [5:0] IDX_PWR_STATUS = 6'h1a;
  localparam logic [5:0] IDX_PHY_CTRL2 = 6'h1f;

  // Field positions.
  localparam int BCR_SOFT_RST = 15;
  localparam int BCR_AN_EN = 12;
  localparam int BCR_PDOWN = 11;
  localparam int DIG_PLL_OFF = 4;
  localparam int AFE0_SLOW_OSC = 6;
  localparam int AFE2_SLOW_KEEP = 0;
  localparam int AFE3_UDS_CPU = 6;
  localparam int AFE3_UDS_ENTER = 5;
  localparam int AFE3_NV_ACCESS = 4;
  localparam int AFE3_UDS_EN = 3;
  localparam int AFE3_SIG_POL = 0;
  localparam int EXP_ENERGY_DETECT_POWERDOWN_OFF = 11;
  localparam int PC2_PWR_SAVE = 10;

  // Values after reset, and the writable-bit mask of register 14h.
  localparam logic [15:0] BASIC_CTRL_RST = 16'h1000;
  localparam logic [15:0] EXP_CTRL_RST = 16'h0800;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [15:0] AFE3_MASK = 16'h007b;

  // Timing: ticks of the link-pulse time base.
  localparam int CLK_NS = 20;
  localparam int SLOW_TICK_NS = 160;
  localparam int SLOW_DIV_CYCLES = SLOW_TICK_NS / CLK_NS;
  localparam int NLP_INTERVAL_US = 16000;
  localparam int REF_TICK_NS = 160;
  localparam int NLP_TICKS = NLP_INTERVAL_US * 1000 / REF_TICK_NS;
  localparam int ENERGY_DETECT_POWERDOWN_STRETCH = 8;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_SAVING = 2'b01,
    PM_PDOWN = 2'b11,
    PM_SLEEP = 2'b10
  } ppm_mode_type;

  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic edet_en;
    logic pll_en;
    logic ref_conn;
    logic slow_osc;
    logic link_pulse;
    logic uds;
    logic soft_rst;
  } ppm_pwr_type;

  typedef struct packed {
    logic energy;
    logic link_up;
    logic core_ok;
    logic ref_clk;
  } ppm_pins_type;

endpackage : ppm_pkg

// >>> ppm_sync.sv
// Two-flop synchronisers with rising-edge detect for the pin inputs.
// Assumes the pins are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module ppm_sync
  import ppm_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire ppm_pins_type pins_i, // Raw pin levels.
  output var ppm_pins_type lvl_o, // Synchronised levels.
  output var ppm_pins_type rise_o // One-cycle rising-edge pulses.
);

  typedef struct packed {
    ppm_pins_type s1;
    ppm_pins_type s2;
    ppm_pins_type s3;
  } ppm_sync_type;

  ppm_sync_type s_q;
  ppm_sync_type s_d;

  // The first stage feeds only the second; edges look at stages two and three.
  always_comb begin
    s_d = s_q;
    s_d.s1 = pins_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Supply-good starts high so leaving reset never looks like a supply loss.
      s_q <= '0;
      s_q.s1.core_ok <= 1'b1;
      s_q.s2.core_ok <= 1'b1;
      s_q.s3.core_ok <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign lvl_o = s_q.s2;
  assign rise_o = s_q.s2 & ~s_q.s3;

endmodule : ppm_sync
`default_nettype wire

// >>> ppm_line_model.sv
// Line-side model: reference clock, cable energy, link and core supply.
// Assumes the bench steers the line levels from the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module ppm_line_model #(
  parameter real REF_HALF_NS = 80.0 // Half period of the reference clock.
) (
  input wire logic energy_req, // Bench request: energy on the cable.
  input wire logic link_req, // Bench request: link partner present.
  input wire logic core_req, // Bench request: core supply present.
  output var logic ref_clock_input, // Free-running reference clock.
  output logic energy_sense, // Energy seen on either pair.
  output logic link_up, // Link established.
  output logic core_pwr_ok // Core supply good.
);
  // The crystal runs free; a small offset keeps its edges off pclk edges.
  initial begin
    ref_clock_input = 1'b0;
    #3.0;
    forever #(REF_HALF_NS) ref_clock_input = ~ref_clock_input;
  end
  // A link cannot exist without cable energy, so it drops with it.
  assign energy_sense = energy_req;
  assign link_up = link_req & energy_req;
  assign core_pwr_ok = core_req;
endmodule : ppm_line_model
`default_nettype wire

// >>> test_phy_power_mode_control.sv
// Self-checking bench for the power-mode controller behind an APB port.
// Assumes the line model drives the pins and the design's package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) check(a, b)
module test_phy_power_mode_control;
  import ppm_pkg::*;
  localparam int NLP = 4;
  typedef struct packed {
    logic [15:0] d;
    logic e;
    logic c;
  } ppm_note_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic ref_clock_input, energy_sense, link_up, core_pwr_ok;
  logic energy_present_out, energy_req, link_req, core_req;
  ppm_pwr_type pwr_o;
  logic [3:0] en;
  int n_fail, check_count, cyc, n_pulse, n_srst, g, np, k;
  ppm_note_type q[$];
  logic [5:0] ri[8] = '{IDX_BASIC_CTRL, IDX_DIG_CTRL, IDX_AFE_CTRL0,
    IDX_AFE_CTRL2, IDX_AFE_CTRL3, IDX_EXP_CTRL, IDX_PWR_STATUS, IDX_PHY_CTRL2};
  logic [15:0] rv[8] = '{16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0800, 16'h0004, 16'h0000};
  assign en = {pwr_o.rx_en, pwr_o.tx_en, pwr_o.edet_en, pwr_o.pll_en};
  ppm_power_ctrl #(.NLP_TICKS_P(NLP)) ppm_power_ctrl_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clock_input(ref_clock_input),
    .energy_sense(energy_sense), .link_up(link_up),
    .core_pwr_ok(core_pwr_ok), .pwr_o(pwr_o),
    .energy_present_out(energy_present_out));
  ppm_line_model ppm_line_model_i (.energy_req(energy_req),
    .link_req(link_req), .core_req(core_req),
    .ref_clock_input(ref_clock_input), .energy_sense(energy_sense),
    .link_up(link_up), .core_pwr_ok(core_pwr_ok));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] a, input logic [31:0] b);
    check_count++;
    if (a !== b) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, a, b);
    end
  endtask : check
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask : settle
  // Every transfer leaves a note; the monitor below judges the answer.
  task automatic apb(input logic w, input logic [5:0] idx,
      input logic [15:0] d, input logic [15:0] x, input logic e,
      input logic c);
    logic [31:0] r;
    r = $urandom();
    q.push_back('{x, e, c});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {r[31:16], d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d, 16'h0000, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [5:0] idx, input logic [15:0] x);
    apb(1'b0, idx, 16'h0000, x, 1'b0, 1'b1);
  endtask : rd
  task automatic rd_err(input logic [5:0] idx);
    apb(1'b0, idx, 16'h0000, 16'h0000, 1'b1, 1'b0);
  endtask : rd_err
  task automatic hw_reset();
    presetn <= 1'b0;
    settle(10);
    presetn <= 1'b1;
    settle(2);
  endtask : hw_reset
  task automatic core_loss();
    core_req <= 1'b0;
    settle(6);
    core_req <= 1'b1;
    settle(6);
  endtask : core_loss
  // Cycles between two link pulses, bounded so a silent line cannot hang.
  task automatic gap_of(output int gap);
    int t0, n;
    n = 0;
    while (pwr_o.link_pulse !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    t0 = cyc;
    @(posedge pclk);
    n = 0;
    while (pwr_o.link_pulse !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    gap = cyc - t0;
  endtask : gap_of
  always @(posedge pclk) begin
    ppm_note_type nt;
    cyc <= cyc + 1;
    if (pwr_o.link_pulse === 1'b1) n_pulse <= n_pulse + 1;
    if (pwr_o.soft_rst === 1'b1) n_srst <= n_srst + 1;
    if (psel && penable && pready === 1'b1) begin
      if (q.size() == 0) n_fail++;
      else begin
        nt = q.pop_front();
        `CHK(pslverr, nt.e);
        if (nt.c) `CHK(prdata, {16'h0000, nt.d});
      end
    end
  end
  initial begin
    #400us;
    n_fail++;
    complete_run();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {energy_req, link_req, presetn} = '0;
    core_req = 1'b1;
    {n_fail, check_count, cyc, n_pulse, n_srst} = '0;
    void'($urandom(32'h9c32));
    hw_reset();
    `CHK(energy_present_out, 1'b1);
    for (k = 0; k < 8; k++) rd(ri[k], rv[k]);
    rd_err(6'h3f);
    energy_req <= 1'b1;
    gap_of(g);
    `CHK((g + 4) / 8, NLP);
    wr(IDX_PHY_CTRL2, 16'h0400);
    settle(2);
    `CHK(en, 4'b0111);
    rd(IDX_PWR_STATUS, 16'h000d);
    link_req <= 1'b1;
    settle(6);
    `CHK(en, 4'b1111);
    link_req <= 1'b0;
    wr(IDX_BASIC_CTRL, 16'h0000);
    settle(6);
    `CHK(en, 4'b1111);
    wr(IDX_BASIC_CTRL, 16'h1000);
    wr(IDX_PHY_CTRL2, 16'h0000);
    wr(IDX_EXP_CTRL, 16'h0000);
    settle(2);
    `CHK(en, 4'b0111);
    gap_of(g);
    `CHK((g + 4) / 8, NLP * ENERGY_DETECT_POWERDOWN_STRETCH);
    wr(IDX_DIG_CTRL, 16'h0010);
    settle(2);
    `CHK(en, 4'b0110);
    wr(IDX_EXP_CTRL, 16'h0800);
    wr(IDX_DIG_CTRL, 16'h0000);
    wr(IDX_BASIC_CTRL, 16'h1800);
    settle(2);
    `CHK(en, 4'b0000);
    np = n_pulse;
    settle(300);
    `CHK(n_pulse, np);
    rd(IDX_BASIC_CTRL, 16'h1800);
    wr(IDX_AFE_CTRL0, 16'h0040);
    settle(2);
    `CHK({pwr_o.ref_conn, pwr_o.slow_osc}, 2'b01);
    `CHK(en, 4'b0000);
    np = n_srst;
    wr(IDX_AFE_CTRL0, 16'h0000);
    wr(IDX_BASIC_CTRL, 16'h1000);
    wr(IDX_BASIC_CTRL, 16'h9000);
    settle(3);
    `CHK(n_srst, np + 1);
    `CHK({en, pwr_o.ref_conn}, 5'b11111);
    rd(IDX_BASIC_CTRL, 16'h1000);
    wr(IDX_AFE_CTRL3, 16'h0001);
    core_loss();
    rd(IDX_AFE_CTRL3, 16'h0000);
    wr(IDX_AFE_CTRL3, 16'h0019);
    wr(IDX_AFE_CTRL2, 16'h0001);
    core_loss();
    rd(IDX_AFE_CTRL3, 16'h0019);
    rd(IDX_AFE_CTRL2, 16'h0001);
    wr(IDX_AFE_CTRL2, 16'h0000);
    `CHK(energy_present_out, 1'b0);
    wr(IDX_AFE_CTRL3, 16'h0018);
    settle(6);
    `CHK(energy_present_out, 1'b1);
    energy_req <= 1'b0;
    settle(6);
    `CHK({pwr_o.uds, energy_present_out}, 2'b10);
    `CHK(en, 4'b0010);
    rd_err(IDX_AFE_CTRL3);
    energy_req <= 1'b1;
    settle(6);
    `CHK({pwr_o.uds, energy_present_out}, 2'b11);
    hw_reset();
    `CHK(pwr_o.uds, 1'b0);
    rd(IDX_AFE_CTRL3, 16'h0000);
    wr(IDX_AFE_CTRL2, 16'h0001);
    wr(IDX_AFE_CTRL3, 16'h0058);
    energy_req <= 1'b0;
    settle(6);
    `CHK({pwr_o.uds, energy_present_out}, 2'b00);
    energy_req <= 1'b1;
    wr(IDX_AFE_CTRL3, 16'h0078);
    settle(2);
    `CHK(pwr_o.uds, 1'b1);
    `CHK(en, 4'b0010);
    rd(IDX_AFE_CTRL3, 16'h0078);
    hw_reset();
    rd(IDX_AFE_CTRL2, 16'h0000);
    complete_run();
  end
endmodule : test_phy_power_mode_control
`default_nettype wire
